//--- scrs_defs.svh
// Purpose: constants of the serial clock/ram slave port
// Assumes: included by its bare name wherever a constant is needed
// Notes:   offsets are byte locations of the 64-byte store
`ifndef SCRS_DEFS_SVH
`define SCRS_DEFS_SVH

// ----------------------------------------------------------------
// store layout
// ----------------------------------------------------------------
`define SCRS_MEM_DEPTH    64
`define SCRS_MEM_WIDTH    8
`define SCRS_PTR_W        6
`define SCRS_OFS_SECONDS  6'h00
`define SCRS_OFS_MINUTES  6'h01
`define SCRS_OFS_CENT_HRS 6'h02
`define SCRS_OFS_DAY      6'h03
`define SCRS_OFS_DATE     6'h04
`define SCRS_OFS_MONTH    6'h05
`define SCRS_OFS_YEARS    6'h06
`define SCRS_OFS_CONTROL  6'h07
`define SCRS_OFS_RAM0     6'h08
`define SCRS_PTR_RESET    6'h00
`define SCRS_PTR_STEP     6'h01

// ----------------------------------------------------------------
// bus constants
// ----------------------------------------------------------------
`define SCRS_ADDR_BYTE    8'hd0
`define SCRS_BIT_LAST     4'h7
`define SCRS_BIT_FULL     4'h8
`define SCRS_FIFO_DEPTH   8

`endif

//--- scrs_pkg.sv
// Purpose: shared types of the serial clock/ram slave port
// Assumes: nothing
// Notes:   state codes written out in binary
package scrs_pkg;

  // ----------------------------------------------------------------
  // link engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCRS_IDLE = 3'b000,
    SCRS_RX   = 3'b001,
    SCRS_ACK  = 3'b010,
    SCRS_TX   = 3'b011,
    SCRS_MACK = 3'b100
  } scrs_state_t;

  // kind of byte being received
  typedef enum logic [1:0] {
    SCRS_K_SLAVE = 2'b00,
    SCRS_K_WORD  = 2'b01,
    SCRS_K_DATA  = 2'b10
  } scrs_kind_t;

endpackage

//--- scrs_fifo.sv
// Purpose: small synchronous fifo with registered output word
// Assumes: one clock, synchronous active-low reset, clock enable
// Notes:   in_ready low while the store is full
`timescale 1ns/1ps
module scrs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import scrs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             ov_r;
  logic [WIDTH-1:0] od_r;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  wire logic push  = in_valid & in_ready;
  wire logic load  = (cnt_r != '0) & (~ov_r | out_ready);
  wire logic drain = ov_r & out_ready;

  // full is honest: only the inner store counts
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = ov_r;
  assign out_data  = od_r;

  // inner store and pointers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else if (clk_en) begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r        <= wr_ptr_r + AW'(1);
      end
      if (load) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // output register, so the word leaves from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ov_r <= 1'b0;
      od_r <= '0;
    end else if (clk_en) begin
      if (load) begin
        ov_r <= 1'b1;
        od_r <= mem_r[rd_ptr_r];
      end else if (drain) begin
        ov_r <= 1'b0;
      end
    end
  end

endmodule

//--- scrs_slave.sv
// Purpose: two-wire slave port onto a 64-byte clock/calendar store
// Assumes: scl/sda oversampled by clk_link; power-fail is a level pin
// Notes:   accepted writes are streamed out on clk_sys through a fifo
`timescale 1ns/1ps
`include "scrs_defs.svh"

// Operation
// - sixty-four byte locations reachable over the bus
// - low seven locations hold calendar values
// - pointer steps after each data byte (code: only after an acked write byte or a master-acked read byte)
// - answer only slave address after start
// - fixed order: calendar, control, then ram
// - power fail aborts transfer, clears pointer
// - ignore bus while power fail holds
// - write loads pointer, then stores successive bytes
// - acknowledge address, word address, each data (code refuses a data byte while the previous write is still pending)
// - read pointer steps only on master ack
// - plain read starts at current pointer
module scrs_slave #(
  parameter int DEPTH = `SCRS_MEM_DEPTH,
  parameter int WIDTH = `SCRS_MEM_WIDTH
) (
  // system clock domain
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // link clock domain
  input  wire logic                    clk_link,
  // two-wire bus pins
  input  wire logic                    scl,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // supply monitor
  input  wire logic                    power_fail_threshold,
  // stream of accepted writes
  output logic                         wr_valid,
  input  wire logic                    wr_ready,
  output logic [`SCRS_PTR_W-1:0]       wr_addr,
  output logic [WIDTH-1:0]             wr_data
);
  import scrs_pkg::*;

  localparam int PW = `SCRS_PTR_W;
  localparam int WW = PW + WIDTH;
  // address as a sized vector, so its top seven bits can be picked out
  localparam logic [7:0] SLV_ADDR = `SCRS_ADDR_BYTE;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // pointer step, six bits so it rolls from the top back to zero
  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = p + `SCRS_PTR_STEP;
  endfunction

  // ----------------------------------------------------------------
  // link-domain synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 6;

  logic              wr_tgl_r;
  logic              ack_tgl_r;
  logic [WW-1:0]     wr_word_r;
  logic [NS-1:0]     sync_in;
  logic [NS-1:0]     sync_s1;
  logic [NS-1:0]     sync_s2;
  logic              scl_q;
  logic              sda_q;

  // foreign levels gathered so that one loop synchronises them all
  assign sync_in = {rst_n, clk_en, scl, sda_in, power_fail_threshold, ack_tgl_r};

  // every pin and every foreign level passes two flops first
  for (genvar g = 0; g < NS; g++) begin : g_sync
    always_ff @(posedge clk_link) begin
      sync_s1[g] <= sync_in[g];
      sync_s2[g] <= sync_s1[g];
    end
  end

  // synced levels by name; nothing but the second stage is ever read
  wire logic lrst_s2 = sync_s2[5];
  wire logic len_s2  = sync_s2[4];
  wire logic scl_s2  = sync_s2[3];
  wire logic sda_s2  = sync_s2[2];
  wire logic pf_s2   = sync_s2[1];
  wire logic ack_s2  = sync_s2[0];

  // third stage gives the previous level for edge decoding
  always_ff @(posedge clk_link) begin
    if (!lrst_s2) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (len_s2) begin
      scl_q <= scl_s2;
      sda_q <= sda_s2;
    end
  end

  // ----------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------
  wire logic cond_start = scl_s2 & scl_q & sda_q & ~sda_s2;
  wire logic cond_stop  = scl_s2 & scl_q & ~sda_q & sda_s2;
  wire logic scl_rise   = scl_s2 & ~scl_q;
  wire logic scl_fall   = ~scl_s2 & scl_q;

  // ----------------------------------------------------------------
  // link engine state
  // ----------------------------------------------------------------
  scrs_state_t       state_r;
  scrs_kind_t        kind_r;
  logic [3:0]        bit_r;
  logic [WIDTH-1:0]  sh_r;
  logic              rw_r;
  logic              mack_r;
  logic [PW-1:0]     ptr_r;
  logic              oe_r;
  logic              pend_r;
  logic [WIDTH-1:0]  mem_r [DEPTH];

  // decoded byte facts
  wire logic          addr_hit  = (sh_r[7:1] == SLV_ADDR[7:1]);
  wire logic          byte_done = scl_fall & (bit_r == `SCRS_BIT_FULL);
  wire logic          tx_done   = scl_fall & (bit_r == `SCRS_BIT_LAST);
  wire logic [WIDTH-1:0] rd_byte = mem_r[ptr_r];
  wire logic          ack_pend  = wr_tgl_r ^ ack_s2;
  wire logic          wr_take   = (state_r == SCRS_RX) & (kind_r == SCRS_K_DATA)
                                  & byte_done & ~pend_r;

  // ----------------------------------------------------------------
  // store and crossing to the system clock
  // ----------------------------------------------------------------
  // store: every write lands at the pointer, calendar bytes included
  always_ff @(posedge clk_link) begin
    if (len_s2 && !pf_s2 && wr_take) begin
      mem_r[ptr_r] <= sh_r;
    end
  end

  // crossing request: word held stable until the toggle is answered
  always_ff @(posedge clk_link) begin
    if (!lrst_s2) begin
      wr_tgl_r  <= 1'b0;
      wr_word_r <= '0;
      pend_r    <= 1'b0;
    end else if (len_s2) begin
      if (wr_take && !pf_s2) begin
        wr_word_r <= {ptr_r, sh_r};
        wr_tgl_r  <= ~wr_tgl_r;
        pend_r    <= 1'b1;
      end else if (!ack_pend) begin
        pend_r    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  // byte engine: bits sampled on scl rise, sda changed on scl fall
  always_ff @(posedge clk_link) begin
    if (!lrst_s2) begin
      state_r <= SCRS_IDLE;
      kind_r  <= SCRS_K_SLAVE;
      bit_r   <= 4'h0;
      sh_r    <= '0;
      rw_r    <= 1'b0;
      mack_r  <= 1'b0;
      ptr_r   <= `SCRS_PTR_RESET;
      oe_r    <= 1'b0;
    end else if (len_s2) begin
      if (pf_s2) begin
        state_r <= SCRS_IDLE;
        ptr_r   <= `SCRS_PTR_RESET;
        oe_r    <= 1'b0;
        bit_r   <= 4'h0;
      end else if (cond_start) begin
        state_r <= SCRS_RX;
        kind_r  <= SCRS_K_SLAVE;
        bit_r   <= 4'h0;
        oe_r    <= 1'b0;
      end else if (cond_stop) begin
        state_r <= SCRS_IDLE;
        oe_r    <= 1'b0;
      end else begin
        unique case (state_r)
          // idle: wait for a start, never pull the line
          SCRS_IDLE: begin
            oe_r <= 1'b0;
          end
          // receive: shift on rise, judge the byte on the fall after the eighth rise
          SCRS_RX: begin
            if (scl_rise && bit_r != `SCRS_BIT_FULL) begin
              sh_r  <= {sh_r[WIDTH-2:0], sda_s2};
              bit_r <= bit_r + 4'h1;
            end else if (byte_done) begin
              unique case (kind_r)
                // a miss leaves the bus alone until the next start
                SCRS_K_SLAVE: begin
                  if (addr_hit) begin
                    rw_r    <= sh_r[0];
                    oe_r    <= 1'b1;
                    state_r <= SCRS_ACK;
                  end else begin
                    state_r <= SCRS_IDLE;
                  end
                end
                // only the low six bits can reach the pointer
                SCRS_K_WORD: begin
                  ptr_r   <= sh_r[PW-1:0];
                  oe_r    <= 1'b1;
                  state_r <= SCRS_ACK;
                end
                default: begin
                  // a byte that cannot be forwarded is refused, not acked
                  if (!pend_r) begin
                    ptr_r   <= ptr_next(ptr_r);
                    oe_r    <= 1'b1;
                    state_r <= SCRS_ACK;
                  end else begin
                    state_r <= SCRS_IDLE;
                  end
                end
              endcase
            end
          end
          // acknowledge slot: release or hand over on the next fall
          SCRS_ACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (kind_r == SCRS_K_SLAVE && rw_r) begin
                sh_r    <= rd_byte;
                oe_r    <= ~rd_byte[WIDTH-1];
                state_r <= SCRS_TX;
              end else begin
                oe_r    <= 1'b0;
                kind_r  <= (kind_r == SCRS_K_SLAVE) ? SCRS_K_WORD : SCRS_K_DATA;
                state_r <= SCRS_RX;
              end
            end
          end
          // transmit: each next bit goes out after a fall
          SCRS_TX: begin
            if (tx_done) begin
              oe_r    <= 1'b0;
              state_r <= SCRS_MACK;
            end else if (scl_fall) begin
              oe_r  <= ~sh_r[WIDTH-2];
              sh_r  <= {sh_r[WIDTH-2:0], 1'b0};
              bit_r <= bit_r + 4'h1;
            end
          end
          // master answer: step only on a low, otherwise go quiet
          SCRS_MACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s2;
              if (!sda_s2) begin
                ptr_r <= ptr_next(ptr_r);
              end
            end else if (scl_fall) begin
              bit_r <= 4'h0;
              if (mack_r) begin
                sh_r    <= rd_byte;
                oe_r    <= ~rd_byte[WIDTH-1];
                state_r <= SCRS_TX;
              end else begin
                state_r <= SCRS_IDLE;
              end
            end
          end
          // unused code: back to idle with the line released
          default: begin
            state_r <= SCRS_IDLE;
            oe_r    <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // only a low is ever driven; a high is left to the pull-up
  always_ff @(posedge clk_link) begin
    if (!lrst_s2) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (len_s2) begin
      sda_out <= 1'b0;
      sda_oe  <= oe_r & ~pf_s2;
    end
  end

  // ----------------------------------------------------------------
  // system-domain side of the crossing
  // ----------------------------------------------------------------
  logic req_s1, req_s2;
  logic fifo_in_ready;

  // toggle from the link passes two flops before it is compared
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else if (clk_en) begin
      req_s1 <= wr_tgl_r;
      req_s2 <= req_s1;
    end
  end

  wire logic sys_pend = req_s2 ^ ack_tgl_r;
  wire logic sys_push = sys_pend & fifo_in_ready;

  // answer the toggle only once the fifo took the word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_tgl_r <= 1'b0;
    end else if (clk_en && sys_push) begin
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  // fifo carries address and data of each accepted write
  scrs_fifo #(
    .WIDTH (WW),
    .DEPTH (`SCRS_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (sys_pend),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_word_r),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

endmodule

//--- scrs_slave_chk_asserts.sv
// Purpose: pin-level checks of the serial clock/ram slave port
// Assumes: sees only the top module's ports
// Notes:   link checks on clk_link, stream checks on clk_sys
`timescale 1ns/1ps
`include "scrs_defs.svh"
module scrs_slave_chk #(
  parameter int DEPTH = `SCRS_MEM_DEPTH,
  parameter int WIDTH = `SCRS_MEM_WIDTH
) (
  // clocks and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic                   clk_en,
  input wire logic                   clk_link,
  // bus pins
  input wire logic                   scl,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire logic                   power_fail_threshold,
  // write stream
  input wire logic                   wr_valid,
  input wire logic                   wr_ready,
  input wire logic [`SCRS_PTR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0]       wr_data
);
  // ------------------------------------------------------------
  // link side
  // ------------------------------------------------------------
  a_pull_low_only: assert property (@(posedge clk_link) disable iff (!rst_n)
    sda_oe |-> sda_out == 1'b0) else $error("sda driven high");
  a_ack_in_low: assert property (@(posedge clk_link) disable iff (!rst_n)
    $rose(sda_oe) |-> !scl) else $error("sda pulled while scl high");
  // power fail may drop the pull at any time, so it is excluded
  a_release_in_low: assert property (@(posedge clk_link)
    disable iff (!rst_n || power_fail_threshold)
    $fell(sda_oe) |-> !scl) else $error("sda released while scl high");
  a_stable_high: assert property (@(posedge clk_link) disable iff (!rst_n)
    (scl && !power_fail_threshold)[*6] |-> $stable(sda_oe)) else $error("sda moved in high");
  a_pf_quiet: assert property (@(posedge clk_link) disable iff (!rst_n)
    power_fail_threshold[*4] |-> !sda_oe) else $error("sda driven in power fail");
  // ------------------------------------------------------------
  // stream side
  // ------------------------------------------------------------
  a_word_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("stream word changed before taken");
  a_taken_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(wr_valid) |-> $past(wr_ready)) else $error("stream word dropped untaken");
  a_reset_clear: assert property (@(posedge clk_sys)
    !rst_n |=> !wr_valid && wr_addr == '0 && wr_data == '0) else $error("reset not clean");
  // main scenarios seen
  c_ack: cover property (@(posedge clk_link) $rose(sda_oe));
  c_stall: cover property (@(posedge clk_sys) wr_valid && !wr_ready);
  c_pf: cover property (@(posedge clk_link) $rose(power_fail_threshold));
endmodule

bind scrs_slave scrs_slave_chk #(.DEPTH(DEPTH), .WIDTH(WIDTH)) scrs_slave_chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .clk_link(clk_link), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .power_fail_threshold(power_fail_threshold), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));

//--- scrs_master_model.sv
// Purpose: behavioural two-wire bus master driving the slave port
// Assumes: sda resolved outside with a pull-up
// Notes:   scl stands high between frames; slow stretches the low phase
`timescale 1ns/1ps
module scrs_master_model #(
  parameter int QTR_NS = 400
) (
  // bus
  input  wire logic sda_wire,
  input  wire logic slow,
  output logic      scl,
  output logic      m_oe
);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // start also serves as repeated start from scl low
  task automatic start_cond();
    m_oe = 1'b0;
    #QTR_NS scl = 1'b1;
    #QTR_NS m_oe = 1'b1;
    #QTR_NS scl = 1'b0;
    #QTR_NS;
  endtask
  task automatic stop_cond();
    m_oe = 1'b1;
    #QTR_NS scl = 1'b1;
    #QTR_NS m_oe = 1'b0;
    #QTR_NS;
  endtask
  // data changes only while scl low, sampled mid-high
  task automatic clock_bit(input logic b, output logic s);
    m_oe = !b;
    #(slow ? 3 * QTR_NS : QTR_NS) scl = 1'b1;
    #QTR_NS s = sda_wire;
    #QTR_NS scl = 1'b0;
    #QTR_NS;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(!mack, s);
  endtask
endmodule

//--- test_serial_clock_ram_slave_access.sv
// Purpose: self-checking bench of the serial clock/ram slave port
// Assumes: master model on the bus, stream drained here
// Notes:   expectations come from the bench's own tables
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_serial_clock_ram_slave_access;
  import scrs_pkg::*;
  // ------------------------------------------------------------
  // pins and bookkeeping
  // ------------------------------------------------------------
  logic        clk_sys, clk_link, rst_n, clk_en, power_fail_threshold, wr_ready, slow;
  wire         scl, m_oe, sda_oe, sda_out, wr_valid, sda_wire;
  wire   [5:0] wr_addr;
  wire   [7:0] wr_data;
  logic        ack;
  int          n_errors, samples_checked;
  logic [13:0] got_q[$];
  logic  [7:0] cal[11] = '{8'h59, 8'h58, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h10,
                           8'h41, 8'h42, 8'h43};
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // link clock free running, phase unrelated
  initial begin
    clk_link = 1'b0;
    #7;
    forever #32 clk_link = ~clk_link;
  end
  assign sda_wire = !m_oe && !(sda_oe && !sda_out); // pull-up, open drain
  scrs_slave scrs_slave_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .clk_link(clk_link), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .power_fail_threshold(power_fail_threshold), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data));
  scrs_master_model scrs_master_model_i (.sda_wire(sda_wire), .slow(slow), .scl(scl),
    .m_oe(m_oe));
  // collect every word taken from the stream
  always @(posedge clk_sys) begin
    if (rst_n && wr_valid && wr_ready) got_q.push_back({wr_addr, wr_data});
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic addr_phase(input logic [7:0] a, input logic exp_ack);
    scrs_master_model_i.start_cond();
    scrs_master_model_i.send_byte(a, ack);
    `CHK(ack, exp_ack)
  endtask
  task automatic put(input logic [7:0] d, input logic exp_ack);
    scrs_master_model_i.send_byte(d, ack);
    `CHK(ack, exp_ack)
  endtask
  task automatic get(input logic mack, input logic [7:0] exp);
    logic [7:0] d;
    scrs_master_model_i.recv_byte(mack, d);
    `CHK(d, exp)
  endtask
  task automatic drain_chk(input int n, input logic [5:0] a0, input int k0);
    logic [13:0] w;
    for (int i = 0; i < 400 && got_q.size() < n; i++) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      // popped once, so a mismatch report shows the word that was compared
      w = 'x;
      if (got_q.size() > 0) w = got_q.pop_front();
      `CHK(w, {6'(a0 + i), cal[k0 + i]})
    end
    `CHK(got_q.size(), 0)
  endtask
  task automatic drive(input logic pf, input logic rdy, input logic sl);
    @(posedge clk_sys);
    power_fail_threshold <= pf;
    wr_ready <= rdy;
    slow <= sl;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_wrap_write();
    addr_phase(8'hd0, 1'b1);
    put(8'h3e, 1'b1);
    for (int i = 8; i < 11; i++) put(cal[i], 1'b1);
    scrs_master_model_i.stop_cond();
    drain_chk(3, 6'h3e, 8);
    $display("test wrap_write done");
  endtask
  task automatic t_read_back();
    drive(1'b0, 1'b1, 1'b1);
    addr_phase(8'ha0, 1'b0);
    scrs_master_model_i.stop_cond();
    addr_phase(8'hd0, 1'b1);
    put(8'h3e, 1'b1);
    addr_phase(8'hd1, 1'b1);
    get(1'b1, cal[8]);
    get(1'b1, cal[9]);
    get(1'b0, cal[10]);
    scrs_master_model_i.stop_cond();
    addr_phase(8'hd1, 1'b1);
    get(1'b0, cal[10]);
    scrs_master_model_i.stop_cond();
    drive(1'b0, 1'b1, 1'b0);
    $display("test read_back done");
  endtask
  task automatic t_fill_drain();
    drive(1'b0, 1'b0, 1'b0);
    addr_phase(8'hd0, 1'b1);
    put(8'h00, 1'b1);
    for (int i = 0; i < 11; i++) begin
      scrs_master_model_i.send_byte(cal[i], ack);
      // eight in the fifo, one in its output flop, one held at the crossing
      `CHK(ack, 1'(i < 10))
    end
    scrs_master_model_i.stop_cond();
    drive(1'b0, 1'b1, 1'b0);
    drain_chk(10, 6'h00, 0);
    $display("test fill_drain done");
  endtask
  task automatic t_power_fail();
    addr_phase(8'hd0, 1'b1);
    put(8'h20, 1'b1);
    drive(1'b1, 1'b1, 1'b0);
    put(8'h66, 1'b0);
    scrs_master_model_i.stop_cond();
    addr_phase(8'hd0, 1'b0);
    put(8'h00, 1'b0);
    scrs_master_model_i.stop_cond();
    drive(1'b0, 1'b1, 1'b0);
    repeat (20) @(posedge clk_sys);
    `CHK(got_q.size(), 0)
    addr_phase(8'hd1, 1'b1);
    get(1'b0, cal[0]);
    scrs_master_model_i.stop_cond();
    $display("test power_fail done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    power_fail_threshold = 1'b0;
    wr_ready = 1'b1;
    slow = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    t_wrap_write();
    t_read_back();
    t_fill_drain();
    t_power_fail();
    print_verdict();
  end
  // about 34 bytes at some 16 us each, with room to spare
  initial begin
    #3000000;
    n_errors++;
    print_verdict();
  end
endmodule
